// >>> src/dcnt_top.sv
// dcnt_top: 16-bit down-counter with single-shot and auto-reload modes
// assumes command inputs are one-cycle pulses on SYS_CLK
// Function
// [R1] one 16-bit counter decrementing toward zero
// [R2] start counts from loaded value, current mode
// [R3] single-shot halts at zero, no reload
// [R4] auto-reload reloads start value, runs until stopped
// [R5] stop command halts the auto-reload counter
// [R6] enabled interrupt raised on each zero crossing
// [R7] interrupt passed straight to host line
// [R8] event enable drives bit 0 as output
// [R9] host must not set bit 0 input then
// [R10] count clock internal oscillator or external pin
// [R11] start value accepts any 16-bit value
// [R12] readback returns loaded start value, not count
// [R13] reset command stops, restores documented defaults
// [R14] event pulse one count-clock period wide
// [R15] external clock synchronised, counts rising edges
`timescale 1ns/1ps
`default_nettype none
module dcnt_top
    import dcnt_pkg::*;
#(
    parameter int WIDTH = DCNT_WIDTH
) (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic LOAD_STROBE,
    input wire logic [WIDTH-1:0] LOAD_VALUE,
    input wire logic START_CMD,
    input wire logic STOP_CMD,
    input wire logic RESET_CMD,
    input wire logic CONFIG_STROBE,
    input wire logic MODE_RELOAD,
    input wire logic ZERO_EVENT_OUTPUT_ENABLE,
    input wire logic COUNT_CLOCK_SELECT,
    input wire logic IRQ_ENABLE,
    input wire logic EXT_COUNT_CLOCK_PIN,
    output logic [WIDTH-1:0] START_VALUE,
    output logic [WIDTH-1:0] COUNT_VALUE,
    output logic RUNNING,
    output logic IRQ,
    output logic MIO0_OUT,
    output logic MIO0_OE_N,
    output logic MIO0_FORCE_OUTPUT
);
    // ------------------------------------------------------------
    // configuration
    // ------------------------------------------------------------
    logic [WIDTH-1:0] start_reg;
    logic mode_reg;
    logic evt_en_reg;
    logic clk_sel_reg;
    logic irq_en_reg;

    // start value survives the reset command; only RST clears it
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            start_reg <= WIDTH'(DCNT_START_RST);
        end else if (LOAD_STROBE && !RESET_CMD) begin
            start_reg <= LOAD_VALUE; // [R11]
        end
    end

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            mode_reg <= DCNT_MODE_RST;
            evt_en_reg <= DCNT_EVT_EN_RST;
            clk_sel_reg <= DCNT_CLK_SEL_RST;
            irq_en_reg <= DCNT_IRQ_EN_RST;
        end else if (RESET_CMD) begin
            mode_reg <= DCNT_MODE_RST; // [R13]
            evt_en_reg <= DCNT_EVT_EN_RST; // [R13]
            clk_sel_reg <= DCNT_CLK_SEL_RST; // [R13]
            irq_en_reg <= DCNT_IRQ_EN_RST; // [R13]
        end else begin
            if (CONFIG_STROBE) begin
                mode_reg <= MODE_RELOAD;
                evt_en_reg <= ZERO_EVENT_OUTPUT_ENABLE;
                clk_sel_reg <= COUNT_CLOCK_SELECT;
                irq_en_reg <= IRQ_ENABLE;
            end
        end
    end

    // ------------------------------------------------------------
    // count clock ticks
    // ------------------------------------------------------------
    logic ext_rise;
    logic [DCNT_PHASE_W-1:0] phase_reg;
    logic [DCNT_PHASE_W:0] phase_sum;
    logic osc_tick;
    logic tick;

    dcnt_sync u_ext_sync (
        .clk(SYS_CLK),
        .rst(RST),
        .din(EXT_COUNT_CLOCK_PIN),
        .rise(ext_rise)
    ); // [R15]

    // oscillator rate is modelled by a phase accumulator on the
    // system clock; ticks jitter by one cycle and average slightly slow, the increment being truncated
    // a faster system clock would only shrink that jitter
    assign phase_sum = {1'b0, phase_reg} + {1'b0, DCNT_OSC_INC};
    assign osc_tick = phase_sum[DCNT_PHASE_W];
    assign tick = (clk_sel_reg == DCNT_CLK_EXTERNAL) ?
        ext_rise : osc_tick; // [R10]

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            phase_reg <= '0;
        end else begin
            phase_reg <= phase_sum[DCNT_PHASE_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // counter state machine
    // ------------------------------------------------------------
    dcnt_state_t state_reg;
    dcnt_state_t state_next;
    logic [WIDTH-1:0] count_reg;
    logic [WIDTH-1:0] count_next;
    logic at_zero;
    logic zero_hit;
    logic evt_reg;
    logic evt_next;
    logic irq_reg;

    assign at_zero = (count_reg == '0);
    // zero reached on a tick while running; a zero start fires on the first tick
    assign zero_hit = (state_reg == DCNT_RUN) & tick &
        (count_reg == WIDTH'(1) | at_zero);

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    logic start_take;
    logic stop_take;
    logic reload_take;
    logic halt_take;

    // a start while running is refused so the period is never cut
    assign start_take = (state_reg == DCNT_IDLE) & START_CMD;
    assign stop_take = (state_reg == DCNT_RUN) & STOP_CMD;
    assign reload_take = zero_hit & (mode_reg == DCNT_MODE_RELOAD);
    assign halt_take = zero_hit & (mode_reg == DCNT_MODE_SINGLE);

    always_comb begin
        state_next = state_reg;
        count_next = count_reg;
        case (state_reg)
            DCNT_IDLE: begin
                if (start_take) begin
                    state_next = DCNT_RUN; // [R2]
                    count_next = start_reg; // [R2]
                end
            end
            DCNT_RUN: begin
                if (tick) begin
                    if (!zero_hit) begin
                        count_next = count_reg - WIDTH'(1); // [R1]
                    end else if (reload_take) begin
                        count_next = start_reg; // [R4]
                    end else if (halt_take) begin
                        count_next = '0;
                        state_next = DCNT_IDLE; // [R3]
                    end
                end
                // stop has effect in either mode
                if (stop_take) begin
                    state_next = DCNT_IDLE; // [R5]
                end
            end
            default: begin
                state_next = DCNT_IDLE;
            end
        endcase
        if (RESET_CMD) begin
            state_next = DCNT_IDLE; // [R13]
        end
    end

    // event held until the next count tick: one count period wide
    assign evt_next = zero_hit ? 1'b1 : (tick ? 1'b0 : evt_reg); // [R14]

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            state_reg <= DCNT_IDLE;
            count_reg <= WIDTH'(DCNT_COUNT_RST);
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
        end
    end

    // ------------------------------------------------------------
    // zero events
    // ------------------------------------------------------------
    // both leave flops so the host line and the pin never glitch
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            evt_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            evt_reg <= evt_next;
            irq_reg <= zero_hit & irq_en_reg; // [R6]
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign START_VALUE = start_reg; // [R12]
    assign COUNT_VALUE = count_reg;
    assign RUNNING = (state_reg == DCNT_RUN);
    assign IRQ = irq_reg; // [R7]
    assign MIO0_OUT = evt_reg & evt_en_reg; // [R8]
    // pin forced to drive; host must keep bit 0 off input meanwhile
    assign MIO0_OE_N = ~evt_en_reg; // [R8] [R9]
    assign MIO0_FORCE_OUTPUT = evt_en_reg; // [R8]
endmodule : dcnt_top
`default_nettype wire

// >>> src/dcnt_pkg.sv
// dcnt_pkg: constants shared by the 16-bit down-counter block
// assumes a 250 MHz system clock driving all logic
package dcnt_pkg;
    localparam int DCNT_WIDTH = 16;
    localparam logic [15:0] DCNT_START_RST = 16'h0000;
    localparam logic [15:0] DCNT_COUNT_RST = 16'h0000;
    // defaults restored by reset or the reset command
    localparam logic DCNT_MODE_RST = 1'b0;
    localparam logic DCNT_EVT_EN_RST = 1'b0;
    localparam logic DCNT_CLK_SEL_RST = 1'b0;
    localparam logic DCNT_IRQ_EN_RST = 1'b0;
    localparam logic DCNT_MODE_SINGLE = 1'b0;
    localparam logic DCNT_MODE_RELOAD = 1'b1;
    localparam logic DCNT_CLK_INTERNAL = 1'b0;
    localparam logic DCNT_CLK_EXTERNAL = 1'b1;
    // internal oscillator rate and system clock rate in Hz, exact
    localparam longint DCNT_OSC_HZ = 64'h0000000000E10000;
    localparam longint DCNT_SYS_HZ = 64'h000000000EE6B280;
    localparam int DCNT_PHASE_W = 24;
    // phase increment per system cycle: osc/sys * 2^24
    localparam logic [23:0] DCNT_OSC_INC =
        24'((DCNT_OSC_HZ << DCNT_PHASE_W) / DCNT_SYS_HZ);
    typedef enum logic [1:0] {
        DCNT_IDLE = 2'b00,
        DCNT_RUN = 2'b01
    } dcnt_state_t;
endpackage : dcnt_pkg

// >>> src/dcnt_sync.sv
// dcnt_sync: three-stage input synchroniser with agreement filter
// assumes the input is asynchronous to clk
`timescale 1ns/1ps
`default_nettype none
module dcnt_sync (
    input wire logic clk,
    input wire logic rst,
    input wire logic din,
    output logic rise
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic level_reg;
    logic level_next;

    // a change counts only once stages two and three agree
    assign level_next = (s2_reg == s3_reg) ? s3_reg : level_reg;
    assign rise = level_next & ~level_reg;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            level_reg <= 1'b0;
        end else begin
            s1_reg <= din;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            level_reg <= level_next;
        end
    end
endmodule : dcnt_sync
`default_nettype wire

// >>> verification/dcnt_checker.sv
// dcnt_checker: port-level assertions on the down-counter
// assumes it is bound into dcnt_top, one clock, async reset
`timescale 1ns/1ps
`default_nettype none
module dcnt_checker #(
    parameter int WIDTH = 16
) (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic LOAD_STROBE,
    input wire logic [WIDTH-1:0] LOAD_VALUE,
    input wire logic START_CMD,
    input wire logic STOP_CMD,
    input wire logic RESET_CMD,
    input wire logic [WIDTH-1:0] START_VALUE,
    input wire logic [WIDTH-1:0] COUNT_VALUE,
    input wire logic RUNNING,
    input wire logic IRQ,
    input wire logic MIO0_OE_N
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (RST);
    start_load_a: assert property (START_CMD && !RUNNING && !STOP_CMD
        && !RESET_CMD && !LOAD_STROBE |=> RUNNING
        && COUNT_VALUE == $past(START_VALUE)) else $error("bad start");
    count_step_a: assert property ($past(RUNNING) && RUNNING
        && $changed(COUNT_VALUE) |-> COUNT_VALUE == $past(COUNT_VALUE) - 1'b1
        || COUNT_VALUE == $past(START_VALUE)) else $error("bad step");
    zero_halt_a: assert property ($fell(RUNNING) && !$past(STOP_CMD)
        && !$past(RESET_CMD) |-> COUNT_VALUE == '0) else $error("bad halt");
    stop_halt_a: assert property (STOP_CMD && !START_CMD
        |=> !RUNNING) else $error("stop ignored");
    reset_cmd_a: assert property (RESET_CMD
        |=> !RUNNING && MIO0_OE_N) else $error("reset ignored");
    load_take_a: assert property (LOAD_STROBE && !RESET_CMD
        |=> START_VALUE == $past(LOAD_VALUE)) else $error("load lost");
    start_hold_a: assert property (!LOAD_STROBE
        |=> $stable(START_VALUE)) else $error("start value moved");
    irq_pulse_a: assert property (IRQ |=> !IRQ)
        else $error("irq too long");
endmodule : dcnt_checker
bind dcnt_top dcnt_checker #(.WIDTH(WIDTH)) u_dcnt_checker (.*);
`default_nettype wire

// >>> verification/dcnt_top_tb.sv
// dcnt_top_tb: table-driven and directed tests of the down-counter
// assumes dcnt_top with its checker bound in; bench drives all ports
`timescale 1ns/1ps
`default_nettype none
module dcnt_top_tb import dcnt_pkg::*;;
    typedef struct {logic [15:0] v, ie, ee, ni, ne;} dcnt_row_t;
    dcnt_row_t rows [3] = '{'{16'h0000, 1, 1, 1, 1},
        '{16'h0003, 0, 1, 0, 1}, '{16'h0002, 1, 0, 1, 0}};
    logic clk = 0, rst = 1, ld = 0, go = 0, stp = 0, rcmd = 0, cfg = 0;
    logic md = 0, ee = 0, cs = 0, ie = 0, ext = 0, mq = 0;
    logic run, irq, mo, oen, fo;
    logic [15:0] ldv = 16'h0000, sv, cv, ni = 16'h0000, ne = 16'h0000, i0, e0;
    int failures = 0, samples_checked = 0, cycles = 0;
    dcnt_top u_dcnt_top (.SYS_CLK(clk), .RST(rst), .LOAD_STROBE(ld),
        .LOAD_VALUE(ldv), .START_CMD(go), .STOP_CMD(stp), .RESET_CMD(rcmd),
        .CONFIG_STROBE(cfg), .MODE_RELOAD(md), .ZERO_EVENT_OUTPUT_ENABLE(ee),
        .COUNT_CLOCK_SELECT(cs), .IRQ_ENABLE(ie), .EXT_COUNT_CLOCK_PIN(ext),
        .START_VALUE(sv), .COUNT_VALUE(cv), .RUNNING(run), .IRQ(irq),
        .MIO0_OUT(mo), .MIO0_OE_N(oen), .MIO0_FORCE_OUTPUT(fo));
    initial forever #2 clk = ~clk;
    always @(posedge clk) begin
        cycles <= cycles + 1;
        mq <= mo;
        if (irq === 1'b1)
            ni <= ni + 16'h0001;
        if (mo === 1'b1 && mq !== 1'b1)
            ne <= ne + 16'h0001;
        if (cycles == 20000) begin
            failures++;
            finish_test();
        end
    end
    task automatic chk(input string n, input logic [15:0] e, g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic finish_test();
        if (failures == 0 && samples_checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : finish_test
    // load and configure together, then start on the next edge
    task automatic setup(input logic m, input logic [15:0] v,
        input logic i, e, c);
        @(posedge clk);
        {ld, cfg, md, ie, ee, cs} <= {2'b11, m, i, e, c};
        ldv <= v;
        @(posedge clk);
        {ld, cfg, go} <= 3'b001;
        @(posedge clk);
        go <= 1'b0;
        i0 = ni;
        e0 = ne;
    endtask : setup
    task automatic wait_idle();
        int k;
        @(posedge clk);
        #1;
        for (k = 0; k < 400 && run !== 1'b0; k++)
            @(posedge clk);
        repeat (3) @(posedge clk);
        #1;
    endtask : wait_idle
    initial begin
        repeat (6) @(posedge clk);
        chk("oe in reset", 16'h0001, {15'h0, oen});
        rst <= 1'b0;
        foreach (rows[n]) begin
            setup(DCNT_MODE_SINGLE, rows[n].v, rows[n].ie[0], rows[n].ee[0], 0);
            wait_idle();
            chk("count", 16'h0000, cv);
            chk("readback", rows[n].v, sv);
            chk("irqs", rows[n].ni, ni - i0);
            chk("events", rows[n].ne, ne - e0);
            chk("oe", {15'h0, ~rows[n].ee[0]}, {15'h0, oen});
            chk("force", {15'h0, rows[n].ee[0]}, {15'h0, fo});
        end
        setup(DCNT_MODE_RELOAD, 16'h0001, 1, 0, DCNT_CLK_INTERNAL);
        repeat (200) @(posedge clk);
        #1;
        chk("reloading", 16'h0001, {15'h0, run});
        chk("irq train", 16'h0001, {15'h0, ni - i0 > 16'h0003});
        @(posedge clk);
        stp <= 1'b1;
        @(posedge clk);
        stp <= 1'b0;
        #1;
        chk("stopped", 16'h0000, {15'h0, run});
        setup(DCNT_MODE_RELOAD, 16'hFFFF, 1, 1, DCNT_CLK_INTERNAL);
        rcmd <= 1'b1;
        @(posedge clk);
        rcmd <= 1'b0;
        #1;
        chk("max load", 16'hFFFF, sv);
        chk("reset oe", 16'h0001, {15'h0, oen});
        chk("reset run", 16'h0000, {15'h0, run});
        chk("reset force", 16'h0000, {15'h0, fo});
        // external edges only; the internal rate must not move the count
        setup(DCNT_MODE_SINGLE, 16'h0002, 0, 0, DCNT_CLK_EXTERNAL);
        repeat (40) @(posedge clk);
        #1;
        chk("ext hold", 16'h0002, cv);
        repeat (4) begin
            @(posedge clk);
            ext <= ~ext;
            repeat (6) @(posedge clk);
        end
        wait_idle();
        chk("ext count", 16'h0000, cv);
        finish_test();
    end
endmodule : dcnt_top_tb
`default_nettype wire
